// *** common/apr_pkg.sv ***
// constants, register layouts and tables of the air pressure channel
package apr_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_CYCLE  = 8'h04;
	localparam logic [7:0] OFS_LIMIT  = 8'h08;
	localparam logic [7:0] OFS_EXT    = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_MEAS   = 8'h14;
	// writable bits; the rest read as zero
	localparam logic [31:0] CTRL_WMASK  = 32'h0000_0377;
	localparam logic [31:0] CYCLE_WMASK = 32'h0000_7F7F;
	localparam logic [31:0] LIMIT_WMASK = 32'h000F_FF7F;
	// reset values
	localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
	localparam logic [31:0] CYCLE_RST = 32'h0000_0000;
	localparam logic [31:0] LIMIT_RST = 32'h0000_0003;
	// time base
	localparam int unsigned CLK_PERIOD_NS = 50;
	localparam int unsigned SEC_NS        = 1000000000;
	localparam int unsigned CYC_PER_S     = SEC_NS / CLK_PERIOD_NS;
	localparam logic [3:0]  HOLD_S        = 4'hA;
	localparam logic [11:0] CYC_UNIT_S    = 12'h00A;
	// span in 0.1 hPa: 300 and 1100 hPa
	localparam logic [15:0] RANGE_LO = 16'h0BB8;
	localparam logic [15:0] RANGE_HI = 16'h2AF8;
	// change steps 0.5, 1, 3, 10 % of the upper range value
	localparam logic [15:0] STEP_TAB [4] = '{16'h0037, 16'h006E, 16'h014A, 16'h044C};
	// thresholds 900, 990 .. 1035, 1100 hPa
	localparam logic [15:0] THR_TAB [12] = '{16'h2328, 16'h26AC, 16'h26DE, 16'h2710,
		16'h2742, 16'h2774, 16'h27A6, 16'h27D8, 16'h280A, 16'h283C, 16'h286E, 16'h2AF8};
	// hysteresis none, 0.3, 0.5, 1, 3, 5 hPa
	localparam logic [15:0] HYST_TAB [6] = '{16'h0000, 16'h0003, 16'h0005, 16'h000A,
		16'h001E, 16'h0032};
	// switch delays in seconds, none up to 60 min
	localparam logic [11:0] DLY_TAB [14] = '{12'h000, 12'h001, 12'h003, 12'h005,
		12'h00A, 12'h00F, 12'h01E, 12'h03C, 12'h0B4, 12'h12C, 12'h258, 12'h384,
		12'h708, 12'hE10};
	// one-byte external value: percent of span, 255 -> full span
	localparam logic [31:0] EXT_SCALE = 32'h0000_07D8;
	localparam int unsigned EXT_SHIFT = 6;

	typedef enum logic [1:0] {EXT_NONE, EXT_16, EXT_8} apr_ext_e;

	typedef struct packed {
		logic [21:0] rsv_b;
		apr_ext_e    ext_md;
		logic        rsv_a;
		logic        lv_chg;
		logic [1:0]  chg_sel;
		logic        rsv_0;
		logic [1:0]  lv_cnt;
		logic        en;
	} apr_ctrl_s;

	typedef struct packed {
		logic [16:0] rsv_b;
		logic [6:0]  l_cyc;
		logic        rsv_a;
		logic [6:0]  m_cyc;
	} apr_cycle_s;

	typedef struct packed {
		logic [11:0] rsv_b;
		logic [3:0]  off_sel;
		logic [3:0]  on_sel;
		logic [3:0]  act;
		logic        rsv_a;
		logic [2:0]  hy_sel;
		logic [3:0]  thr_sel;
	} apr_limit_s;

	typedef struct packed {
		logic [15:0] last;
		logic [11:0] rsv;
		logic        ext_ok;
		logic        pend;
		logic        cond;
		logic        lv;
	} apr_status_s;
endpackage : apr_pkg

// *** verilog/apr_channel.sv ***
// air pressure channel: change and cyclic reports, limit comparator, wishbone registers
//
// Our own choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ns
module apr_channel #(
	parameter int unsigned CYC_PER_S = apr_pkg::CYC_PER_S
) (
	// clock and reset
	input  wire logic        clk_sys_i,
	input  wire logic        reset_n_i,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// pressure samples in 0.1 hPa
	input  wire logic        sample_valid_i,
	input  wire logic [15:0] sample_i,
	// telegram requests
	output logic             meas_send_o,
	output logic      [15:0] meas_value_o,
	output logic             limit_send_o,
	output logic             limit_value_o
);
	typedef struct packed {
		logic                ack;
		logic [31:0]         dat;
		apr_pkg::apr_ctrl_s  ctrl;
		apr_pkg::apr_cycle_s cyc;
		apr_pkg::apr_limit_s lim;
		logic [15:0]         ext_raw;
		logic                ext_ok;
		logic [24:0]         pre;
		logic [3:0]          hold_s;
		logic [11:0]         m_tmr;
		logic [11:0]         l_tmr;
		logic [11:0]         dly_s;
		logic                pend;
		logic [15:0]         smp;
		logic [15:0]         last;
		logic                cond;
		logic                lv;
		logic                m_send;
		logic                l_send;
	} apr_state_s;

	apr_state_s  r;
	apr_state_s  next_r;
	logic        sec_tick;
	logic        active;
	logic        lim_on;
	logic        exc;
	logic        prim_on;
	logic        tgt;
	logic        tgt_ok;
	logic        chg_fire;
	logic        m_fire;
	logic        l_fire;
	logic        l_chg;
	logic        wr;
	logic [15:0] smp_c;
	logic [15:0] limit_threshold;
	logic [15:0] hyst;
	logic [15:0] absdiff;
	logic [31:0] rd;
	logic [31:0] wv;
	logic [31:0] wmask;

	function automatic logic [15:0] span(input logic [15:0] v);
		if (v < apr_pkg::RANGE_LO) begin
			return apr_pkg::RANGE_LO;
		end else if (v > apr_pkg::RANGE_HI) begin
			return apr_pkg::RANGE_HI;
		end
		return v;
	endfunction : span

	always_comb begin
		next_r = r;
		m_fire = 1'b0;
		l_fire = 1'b0;
		l_chg = 1'b0;
		// bus: one wait state, unmapped reads zero and ignores writes
		wr = wb_cyc_i && wb_stb_i && wb_we_i && !r.ack;
		rd = 32'h0;
		if (wb_adr_i == apr_pkg::OFS_CTRL) begin
			rd = r.ctrl;
		end else if (wb_adr_i == apr_pkg::OFS_CYCLE) begin
			rd = r.cyc;
		end else if (wb_adr_i == apr_pkg::OFS_LIMIT) begin
			rd = r.lim;
		end else if (wb_adr_i == apr_pkg::OFS_EXT) begin
			rd = {16'h0, r.ext_raw};
		end else if (wb_adr_i == apr_pkg::OFS_STATUS) begin
			rd = apr_pkg::apr_status_s'({r.last, 12'h0, r.ext_ok, r.pend, r.cond, r.lv});
		end else if (wb_adr_i == apr_pkg::OFS_MEAS) begin
			rd = {limit_threshold, r.smp};
		end
		for (int i = 0; i < 4; i++) begin
			wmask[8*i +: 8] = {8{wb_sel_i[i]}};
		end
		wv = (rd & ~wmask) | (wb_dat_i & wmask);
		next_r.ack = wb_cyc_i && wb_stb_i && !r.ack;
		next_r.dat = rd;
		// a new control or limit setting drops any external threshold until rewritten
		if (wr && wb_adr_i == apr_pkg::OFS_CTRL) begin
			next_r.ctrl = apr_pkg::apr_ctrl_s'(wv & apr_pkg::CTRL_WMASK);
			next_r.ext_ok = 1'b0;
		end else if (wr && wb_adr_i == apr_pkg::OFS_CYCLE) begin
			next_r.cyc = apr_pkg::apr_cycle_s'(wv & apr_pkg::CYCLE_WMASK);
		end else if (wr && wb_adr_i == apr_pkg::OFS_LIMIT) begin
			next_r.lim = apr_pkg::apr_limit_s'(wv & apr_pkg::LIMIT_WMASK);
			next_r.ext_ok = 1'b0;
		end else if (wr && wb_adr_i == apr_pkg::OFS_EXT) begin
			next_r.ext_raw = wv[15:0];
			next_r.ext_ok = 1'b1;
		end

		// one second time base
		sec_tick = (r.pre == 25'(CYC_PER_S - 1));
		next_r.pre = sec_tick ? 25'h0 : r.pre + 25'h1;
		active = r.ctrl.en;
		lim_on = active && (r.ctrl.lv_cnt != 2'h0);
		smp_c = span(sample_i);
		if (sample_valid_i && active) begin
			next_r.smp = smp_c;
		end

		// threshold: internal list or external object
		// 8-bit object is percent of span; 255 lands on the upper bound
		limit_threshold = apr_pkg::THR_TAB[(r.lim.thr_sel > 4'hB) ? 4'hB : r.lim.thr_sel];
		if (r.ext_ok && r.ctrl.ext_md == apr_pkg::EXT_16) begin
			limit_threshold = span(r.ext_raw);
		end else if (r.ext_ok && r.ctrl.ext_md == apr_pkg::EXT_8) begin
			limit_threshold = apr_pkg::RANGE_LO
				+ 16'((32'(r.ext_raw[7:0]) * apr_pkg::EXT_SCALE) >> apr_pkg::EXT_SHIFT);
		end
		hyst = apr_pkg::HYST_TAB[(r.lim.hy_sel > 3'h5) ? 3'h5 : r.lim.hy_sel];

		// comparator: strict crossing sets, strictly passing the hysteresis point clears
		exc = !r.lim.act[1];
		prim_on = !r.lim.act[0];
		if (sample_valid_i && lim_on) begin
			if (exc && smp_c > limit_threshold) begin
				next_r.cond = 1'b1;
			end else if (exc && smp_c < limit_threshold - hyst) begin
				next_r.cond = 1'b0;
			end else if (!exc && smp_c < limit_threshold) begin
				next_r.cond = 1'b1;
			end else if (!exc && smp_c > limit_threshold + hyst) begin
				next_r.cond = 1'b0;
			end
		end
		tgt = r.cond ? prim_on : !prim_on;
		tgt_ok = (r.lim.act < 4'hC)
			&& (r.cond ? (r.lim.act[3:2] != 2'h2) : (r.lim.act[3:2] != 2'h1));

		// delayed acceptance; a target that flips back cancels the wait
		// free-running ticks: an n second delay ends after n-1 to n seconds
		if (!lim_on || !tgt_ok || tgt == r.lv) begin
			next_r.pend = 1'b0;
		end else if (!r.pend) begin
			next_r.pend = 1'b1;
			next_r.dly_s = tgt ? apr_pkg::DLY_TAB[(r.lim.on_sel > 4'hD) ? 4'hD : r.lim.on_sel]
				: apr_pkg::DLY_TAB[(r.lim.off_sel > 4'hD) ? 4'hD : r.lim.off_sel];
		end else if (r.dly_s == 12'h0) begin
			next_r.lv = tgt;
			next_r.pend = 1'b0;
			l_chg = 1'b1;
		end else if (sec_tick) begin
			next_r.dly_s = r.dly_s - 12'h1;
		end

		// change-triggered measured value
		absdiff = (r.smp > r.last) ? r.smp - r.last : r.last - r.smp;
		chg_fire = active && r.hold_s == 4'h0
			&& absdiff >= apr_pkg::STEP_TAB[r.ctrl.chg_sel];
		if (chg_fire) begin
			next_r.hold_s = apr_pkg::HOLD_S;
		end else if (sec_tick && r.hold_s != 4'h0) begin
			next_r.hold_s = r.hold_s - 4'h1;
		end

		// cyclic timers share only the time base, never each other's state
		if (!active || r.cyc.m_cyc == 7'h0) begin
			next_r.m_tmr = 12'h0;
		end else if (sec_tick && r.m_tmr <= 12'h1) begin
			m_fire = 1'b1;
			next_r.m_tmr = 12'(r.cyc.m_cyc) * apr_pkg::CYC_UNIT_S;
		end else if (sec_tick) begin
			next_r.m_tmr = r.m_tmr - 12'h1;
		end
		if (!lim_on || r.cyc.l_cyc == 7'h0) begin
			next_r.l_tmr = 12'h0;
		end else if (sec_tick && r.l_tmr <= 12'h1) begin
			l_fire = 1'b1;
			next_r.l_tmr = 12'(r.cyc.l_cyc) * apr_pkg::CYC_UNIT_S;
		end else if (sec_tick) begin
			next_r.l_tmr = r.l_tmr - 12'h1;
		end

		next_r.m_send = chg_fire || m_fire;
		if (chg_fire || m_fire) begin
			next_r.last = r.smp;
		end
		// cyclic sends carry the accepted state, not the pending one
		next_r.l_send = (l_chg && r.ctrl.lv_chg) || (l_fire && tgt_ok);
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			r <= '0;
			r.ctrl <= apr_pkg::CTRL_RST;
			r.cyc <= apr_pkg::CYCLE_RST;
			r.lim <= apr_pkg::LIMIT_RST;
		end else begin
			r <= next_r;
		end
	end

	assign wb_ack_o = r.ack;
	assign wb_dat_o = r.dat;
	assign meas_send_o = r.m_send;
	assign meas_value_o = r.last;
	assign limit_send_o = r.l_send;
	assign limit_value_o = r.lv;

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!reset_n_i);

	sequence s_lv_rise;
		$rose(r.lv);
	endsequence
	sequence s_lv_fall;
		$fell(r.lv);
	endsequence
	sequence s_chg_send;
		chg_fire ##1 r.m_send;
	endsequence

	chk_inert_quiet: assert property (!r.ctrl.en |=> !r.m_send && !r.l_send)
		else $error("disabled channel sent a telegram");
	chk_span_bound: assert property (limit_threshold >= apr_pkg::RANGE_LO
		&& limit_threshold <= apr_pkg::RANGE_HI && r.smp <= apr_pkg::RANGE_HI)
		else $error("value outside measuring span");
	chk_change_value: assert property (s_chg_send |-> r.last == $past(r.smp))
		else $error("change send did not carry the sample");
	chk_holdoff_load: assert property (chg_fire |=> r.hold_s == apr_pkg::HOLD_S && !chg_fire)
		else $error("holdoff not loaded after change send");
	chk_holdoff_block: assert property (r.hold_s != 4'h0 |-> !chg_fire)
		else $error("change send inside holdoff");
	chk_cycle_off: assert property (r.cyc.m_cyc == 7'h0 |=> !r.m_send || $past(chg_fire))
		else $error("cyclic send while period is zero");
	chk_timer_indep: assert property (m_fire && !chg_fire && r.hold_s != 4'h0
		|=> r.hold_s == $past(r.hold_s) - 4'h1)
		else $error("cyclic send disturbed the holdoff");
	chk_no_comp: assert property (r.ctrl.lv_cnt == 2'h0 |=> !r.l_send)
		else $error("limit sent with no comparator");
	chk_thr_list: assert property (!r.ext_ok |-> limit_threshold >= apr_pkg::THR_TAB[0]
		&& limit_threshold <= apr_pkg::THR_TAB[11])
		else $error("internal threshold off the list");
	chk_band_hold: assert property (sample_valid_i && lim_on && exc
		&& smp_c <= limit_threshold && smp_c >= limit_threshold - hyst |=> $stable(r.cond))
		else $error("state changed inside hysteresis band");
	chk_mode_zero: assert property (r.lim.act == 4'h0 |-> tgt == r.cond && tgt_ok)
		else $error("mode zero target wrong");
	chk_none_quiet: assert property (l_fire && !tgt_ok |=> !r.l_send)
		else $error("cyclic limit sent under no-telegram condition");
	chk_ext_take: assert property (r.ext_ok && r.ctrl.ext_md == apr_pkg::EXT_16
		|-> limit_threshold == span(r.ext_raw))
		else $error("external threshold not used");
	chk_on_delay: assert property (s_lv_rise |-> $past(r.pend) && $past(r.dly_s) == 12'h0)
		else $error("limit rose before switch-on delay");
	chk_off_delay: assert property (s_lv_fall |-> $past(r.pend) && $past(r.dly_s) == 12'h0)
		else $error("limit fell before switch-off delay");
	chk_lv_send: assert property ($changed(r.lv) && $past(r.ctrl.lv_chg) |-> r.l_send)
		else $error("limit change not sent");
	chk_cyc_reload: assert property (m_fire
		|=> r.m_tmr == 12'($past(r.cyc.m_cyc)) * apr_pkg::CYC_UNIT_S)
		else $error("cyclic period not reloaded");
	chk_cyc_indep: assert property (chg_fire && !sec_tick && r.cyc.m_cyc != 7'h0
		|=> $stable(r.m_tmr))
		else $error("change send disturbed the cyclic timer");
endmodule : apr_channel

// *** sim/apr_sensor_model.sv ***
// pressure sensor model: one sample pulse per request
`timescale 1ns/1ns
module apr_sensor_model (
	// clock
	input  wire logic        clk_i,
	// sample stream
	output logic             valid_o,
	output logic      [15:0] value_o
);
	initial begin
		valid_o = 1'b0;
		value_o = 16'h0000;
	end
	// called just after an edge; the released line shows the inverse, never a stale copy
	task put(input logic [15:0] v);
		valid_o <= 1'b1;
		value_o <= v;
		@(posedge clk_i);
		valid_o <= 1'b0;
		value_o <= ~v;
	endtask : put
endmodule : apr_sensor_model

// *** sim/apr_channel_tb.sv ***
// self-checking bench of the air pressure channel
`timescale 1ns/1ns
module apr_channel_tb;
	localparam int CPS = 20;
	logic        clk_sys_i = 1'b0;
	logic        reset_n_i = 1'b0;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [3:0]  sel = 4'h0;
	logic [31:0] wdat = 32'h0000_0000;
	logic [31:0] dat_o;
	logic [31:0] rd;
	logic        ack;
	logic        s_vld;
	logic [15:0] s_val;
	logic        m_send;
	logic [15:0] m_val;
	logic        l_send;
	logic        l_val;
	int          n_fail = 0;
	int          num_checks = 0;
	int          cyc_n = 0;
	int          n_meas = 0;
	int          n_lim = 0;
	int          q_t[$];
	logic [15:0] q_v[$];

	always #25 clk_sys_i = ~clk_sys_i;

	apr_sensor_model i_sens (.clk_i(clk_sys_i), .valid_o(s_vld), .value_o(s_val));

	apr_channel #(.CYC_PER_S(CPS)) i_dut (
		.clk_sys_i     (clk_sys_i),
		.reset_n_i     (reset_n_i),
		.wb_cyc_i      (cyc),
		.wb_stb_i      (stb),
		.wb_we_i       (we),
		.wb_adr_i      (adr),
		.wb_sel_i      (sel),
		.wb_dat_i      (wdat),
		.wb_dat_o      (dat_o),
		.wb_ack_o      (ack),
		.sample_valid_i(s_vld),
		.sample_i      (s_val),
		.meas_send_o   (m_send),
		.meas_value_o  (m_val),
		.limit_send_o  (l_send),
		.limit_value_o (l_val)
	);

	// telegram log; values sampled at the edge that ends each pulse
	always @(posedge clk_sys_i) begin
		cyc_n++;
		if (cyc_n > 20000) begin
			n_fail++;
			results();
		end
		if (m_send === 1'b1) begin
			n_meas++;
			q_t.push_back(cyc_n);
			q_v.push_back(m_val);
		end
		if (l_send === 1'b1)
			n_lim++;
	end

	task check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'hF;
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (n >= 50) begin
			n_fail++;
			results();
		end
		rd = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_sys_i);
	endtask : wb

	task rdc(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0000_0000);
		check(rd, e);
	endtask : rdc

	// five cycles cover the sample-to-output latency of both paths
	task smp(input logic [15:0] v);
		i_sens.put(v);
		repeat (5) @(posedge clk_sys_i);
	endtask : smp

	task results();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : results

	initial begin
		int c, a, k, r, v;
		logic pv, e;
		void'($urandom(32'hbf4b));
		repeat (5) @(posedge clk_sys_i);
		reset_n_i <= 1'b1;
		@(posedge clk_sys_i);
		rdc(apr_pkg::OFS_CTRL, apr_pkg::CTRL_RST);
		rdc(apr_pkg::OFS_CYCLE, apr_pkg::CYCLE_RST);
		rdc(apr_pkg::OFS_LIMIT, apr_pkg::LIMIT_RST);
		wb(1'b1, 8'h18, 32'hFFFF_FFFF);
		rdc(8'h18, 32'h0000_0000);
		wb(1'b1, apr_pkg::OFS_CYCLE, 32'hFFFF_FFFF);
		rdc(apr_pkg::OFS_CYCLE, apr_pkg::CYCLE_WMASK);
		wb(1'b1, apr_pkg::OFS_CYCLE, 32'h0000_0000);
		smp(16'h2710);
		check(n_meas, 0);
		$display("registers and enable done");
		wb(1'b1, apr_pkg::OFS_LIMIT, 32'h0000_0033);
		wb(1'b1, apr_pkg::OFS_CTRL, 32'h0000_0073);
		smp(16'h4E20);
		check(n_meas, 1);
		check(q_v[$], 16'h2AF8);
		smp(16'h0000);
		check(n_meas, 1);
		repeat (220) @(posedge clk_sys_i);
		smp(16'h0000);
		check(n_meas, 2);
		check(q_t[1] - q_t[0] >= 9 * CPS, 1'b1);
		check(q_v[$], 16'h0BB8);
		wb(1'b1, apr_pkg::OFS_CTRL, 32'h0000_0053);
		repeat (220) @(posedge clk_sys_i);
		smp(16'h0C1C);
		check(n_meas, 2);
		smp(16'h0C30);
		check(n_meas, 3);
		$display("change sends done");
		r = $urandom_range(11000, 3000);
		smp(16'(r));
		repeat (220) @(posedge clk_sys_i);
		q_t.delete();
		q_v.delete();
		wb(1'b1, apr_pkg::OFS_CYCLE, 32'h0000_0001);
		repeat (330) @(posedge clk_sys_i);
		check(q_t.size(), 2);
		check(q_t[1] - q_t[0], 10 * CPS);
		check(q_v[1], 16'(r));
		smp(r > 7000 ? 16'h0BB8 : 16'h2AF8);
		repeat (120) @(posedge clk_sys_i);
		check(q_t.size(), 4);
		check(q_t[3] - q_t[1], 10 * CPS);
		wb(1'b1, apr_pkg::OFS_CYCLE, 32'h0000_0000);
		q_t.delete();
		repeat (250) @(posedge clk_sys_i);
		check(q_t.size(), 0);
		$display("cyclic sends done");
		for (a = 0; a < 12; a++) begin
			wb(1'b1, apr_pkg::OFS_LIMIT, 32'(a));
			wb(1'b0, apr_pkg::OFS_MEAS, 32'h0000_0000);
			check(rd[31:16], a == 0 ? 9000 : (a == 11 ? 11000 : 9850 + 50 * a));
		end
		wb(1'b1, apr_pkg::OFS_LIMIT, 32'h0000_0033);
		smp(16'h26DE);
		e = 1'b0;
		c = n_lim;
		// primary crossing, opposite crossing past hysteresis, inside band, primary again
		for (a = 0; a < 12; a++) begin
			wb(1'b1, apr_pkg::OFS_LIMIT, 32'h0000_0033 | 32'(a << 8));
			pv = ~a[0];
			for (k = 0; k < 4; k++) begin
				v = ((k == 1) ^ a[1]) ? 9950 : 10050;
				if (k == 2)
					v = a[1] ? 10005 : 9995;
				smp(16'(v));
				if (k != 1 && k != 2 && a[3:2] != 2 && e != pv) begin
					e = pv;
					c++;
				end
				if (k == 1 && a[3:2] != 1 && e == pv) begin
					e = ~pv;
					c++;
				end
				check(l_val, e);
				check(n_lim - c, 0);
			end
		end
		$display("action modes done");
		wb(1'b1, apr_pkg::OFS_LIMIT, 32'h0000_0433);
		smp(16'h2742);
		smp(16'h26DE);
		check(l_val, 1'b1);
		c = n_lim;
		wb(1'b1, apr_pkg::OFS_CYCLE, 32'h0000_0100);
		repeat (330) @(posedge clk_sys_i);
		check(n_lim - c, 0);
		smp(16'h2742);
		repeat (420) @(posedge clk_sys_i);
		check(n_lim - c >= 2, 1'b1);
		wb(1'b1, apr_pkg::OFS_CYCLE, 32'h0000_0000);
		wb(1'b1, apr_pkg::OFS_LIMIT, 32'h0002_3033);
		smp(16'h26DE);
		repeat (25) @(posedge clk_sys_i);
		check(l_val, 1'b1);
		repeat (50) @(posedge clk_sys_i);
		check(l_val, 1'b0);
		smp(16'h2742);
		repeat (55) @(posedge clk_sys_i);
		check(l_val, 1'b0);
		repeat (50) @(posedge clk_sys_i);
		check(l_val, 1'b1);
		$display("delays done");
		wb(1'b1, apr_pkg::OFS_CTRL, 32'h0000_0173);
		wb(1'b1, apr_pkg::OFS_EXT, 32'h0000_2904);
		wb(1'b0, apr_pkg::OFS_MEAS, 32'h0000_0000);
		check(rd[31:16], 16'h2904);
		wb(1'b1, apr_pkg::OFS_CTRL, 32'h0000_0273);
		wb(1'b1, apr_pkg::OFS_EXT, 32'h0000_0080);
		wb(1'b0, apr_pkg::OFS_MEAS, 32'h0000_0000);
		check(rd[31:16], 16'h1B68);
		$display("external threshold done");
		// steps 0.5 % and 3 %: one below the step stays quiet, the step itself sends
		for (k = 0; k < 2; k++) begin
			wb(1'b1, apr_pkg::OFS_CTRL, 32'h0000_0043 | 32'(k << 5));
			repeat (220) @(posedge clk_sys_i);
			smp(m_val);
			repeat (220) @(posedge clk_sys_i);
			c = n_meas;
			v = m_val + (k ? 330 : 55);
			smp(16'(v - 1));
			check(n_meas - c, 0);
			smp(16'(v));
			check(n_meas - c, 1);
			check(m_val, 16'(v));
		end
		$display("change steps done");
		results();
	end
endmodule : apr_channel_tb
